/* File: qec_counter.sv */
`timescale 1ns/10ps
`include "qec_defines.svh"
// Contract
// - two input interpretations: quadrature or step plus direction
// - quadrature direction taken from which phase edge comes first
// - step mode: phase a rising steps, phase b level gives direction
// - position and direction tracked from pulses and phase lead
// - single-phase capture counts both edges of phase a only
// - dual-phase capture counts every edge of both phases
// - counter equal to wrap limit returns to zero
// - software holds the position wrap limit
// - index clear enabled clears position on each index pulse while running
// - swap exchanges phases a and b before decoding
// - config bit 0x8 selects dual-phase capture
// - config bit 0x10 enables index clear
// - config bit 0x4 selects step plus direction
// - config bit 0x2 enables phase exchange
// - velocity counts events over tick window; zero window disables
// - velocity events pass a programmable pre-divider first
// - counting only after start, stops after stop
// - direction reads plus one forward, minus one reverse
// - software reads position and may overwrite it
module qec_counter (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        reset,
   // encoder pins
   input  wire logic        enc_a,
   input  wire logic        enc_b,
   input  wire logic        enc_index,
   // axi4-lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // axi4-lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   // pin synchronisers
   logic [2:0]  sync1_q;
   logic [2:0]  sync2_q;
   // software state
   logic [4:0]  config_q;
   logic        run_q;
   logic [31:0] limit_q;
   logic [31:0] window_q;
   logic [31:0] divider_q;
   // counting state
   logic [31:0] position_q;
   logic [31:0] direction_q;
   logic [31:0] velocity_q;
   logic        vel_valid_q;
   logic [31:0] tick_q;
   logic [31:0] div_cnt_q;
   logic [31:0] vel_acc_q;
   logic        ev_div;
   // bus write side
   logic        aw_held_q;
   logic        w_held_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   qec_pkg::qec_wr_state_t wr_state_q;
   logic        wr_fire;
   logic [31:0] wr_word;
   logic        pos_write;
   // bus read side
   logic        ar_fire;

   qec_step_if ev ();

   // write lanes merged onto an old word
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // address match, used by the write decode only; reads decode the address in a case
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      return a[7:2] == o[7:2];
   endfunction : hit

   // two flops per pin; only the second stage is read
   always_ff @(posedge clock) begin
      if (reset) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
      end else begin
         sync1_q <= {enc_index, enc_b, enc_a};
         sync2_q <= sync1_q;
      end
   end

   qec_edge_decode u_decode (
      .clock             (clock),
      .reset             (reset),
      .pha               (sync2_q[0]),
      .phb               (sync2_q[1]),
      .idx               (sync2_q[2]),
      .exchange          (config_q[`QEC_CFG_EXCHANGE]),
      .step_dir_select   (config_q[`QEC_CFG_STEP_DIR]),
      .count_both_phases (config_q[`QEC_CFG_BOTH]),
      .ev                (ev)
   );

   // write channel: address and data taken in either order
   assign s_axi_awready = ~aw_held_q & (wr_state_q == qec_pkg::QEC_WR_IDLE);
   assign s_axi_wready  = ~w_held_q & (wr_state_q == qec_pkg::QEC_WR_IDLE);
   assign wr_fire       = aw_held_q & w_held_q &
                          (wr_state_q == qec_pkg::QEC_WR_IDLE);

   // capture write address and data
   always_ff @(posedge clock) begin
      if (reset) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held_q <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held_q <= 1'b0;
         end
      end
   end

   // write response, slverr on an unmapped or read-only word
   always_ff @(posedge clock) begin
      if (reset) begin
         wr_state_q   <= qec_pkg::QEC_WR_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= qec_pkg::QEC_RESP_OKAY;
      end else begin
         unique case (wr_state_q)
            qec_pkg::QEC_WR_IDLE: begin
               if (wr_fire) begin
                  wr_state_q   <= qec_pkg::QEC_WR_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp  <= ({2'b00, awaddr_q[7:2]} <=
                                   (`QEC_POSITION_OFF >> 2))
                                  ? qec_pkg::QEC_RESP_OKAY
                                  : qec_pkg::QEC_RESP_SLVERR;
               end
            end
            qec_pkg::QEC_WR_RESP: begin
               if (s_axi_bready) begin
                  wr_state_q   <= qec_pkg::QEC_WR_IDLE;
                  s_axi_bvalid <= 1'b0;
               end
            end
            default: begin
               wr_state_q   <= qec_pkg::QEC_WR_IDLE;
               s_axi_bvalid <= 1'b0;
            end
         endcase
      end
   end

   // setup registers
   always_ff @(posedge clock) begin
      if (reset) begin
         config_q  <= 5'h00;
         run_q     <= 1'b0;
         limit_q   <= `QEC_ZERO32;
         window_q  <= `QEC_ZERO32;
         divider_q <= `QEC_ZERO32;
      end else if (wr_fire) begin
         if (hit(awaddr_q, `QEC_CONFIG_OFF) & wstrb_q[0]) begin
            config_q <= wdata_q[4:0];
         end
         if (hit(awaddr_q, `QEC_CONTROL_OFF) & wstrb_q[0]) begin
            run_q <= wdata_q[`QEC_CTL_RUN];
         end
         if (hit(awaddr_q, `QEC_LIMIT_OFF)) begin
            limit_q <= merge(limit_q, wdata_q, wstrb_q);
         end
         if (hit(awaddr_q, `QEC_WINDOW_OFF)) begin
            window_q <= merge(window_q, wdata_q, wstrb_q);
         end
         if (hit(awaddr_q, `QEC_DIVIDER_OFF)) begin
            divider_q <= merge(divider_q, wdata_q, wstrb_q);
         end
      end
   end

   assign wr_word   = merge(position_q, wdata_q, wstrb_q);
   assign pos_write = wr_fire & hit(awaddr_q, `QEC_POSITION_OFF);

   // position and direction; software write wins, then index, then step
   always_ff @(posedge clock) begin
      if (reset) begin
         position_q  <= `QEC_ZERO32;
         direction_q <= `QEC_DIR_FWD;
      end else if (pos_write) begin
         position_q <= wr_word;
      end else if (run_q) begin
         if (ev.index & config_q[`QEC_CFG_INDEX]) begin
            position_q <= `QEC_ZERO32;
         end else if (ev.step) begin
            direction_q <= ev.up ? `QEC_DIR_FWD : `QEC_DIR_REV;
            if (ev.up) begin
               // equality to the limit wraps; limit zero gives the full 32-bit range
               position_q <= (position_q + 32'h1 == limit_q)
                             ? `QEC_ZERO32 : position_q + 32'h1;
            end else begin
               position_q <= (position_q == `QEC_ZERO32)
                             ? limit_q - 32'h1 : position_q - 32'h1;
            end
         end
      end
   end

   // divider 0 and 1 both pass every event, so no divide-by-zero case
   assign ev_div = ev.step & (div_cnt_q + 32'h1 >= divider_q);

   // velocity: divided events counted per window of ticks
   always_ff @(posedge clock) begin
      if (reset) begin
         tick_q      <= `QEC_ZERO32;
         div_cnt_q   <= `QEC_ZERO32;
         vel_acc_q   <= `QEC_ZERO32;
         velocity_q  <= `QEC_ZERO32;
         vel_valid_q <= 1'b0;
      end else if (!run_q || window_q == `QEC_ZERO32) begin
         tick_q      <= `QEC_ZERO32;
         div_cnt_q   <= `QEC_ZERO32;
         vel_acc_q   <= `QEC_ZERO32;
         vel_valid_q <= 1'b0;
      end else begin
         if (ev.step) begin
            if (ev_div) begin
               div_cnt_q <= `QEC_ZERO32;
            end else begin
               div_cnt_q <= div_cnt_q + 32'h1;
            end
         end
         if (tick_q + 32'h1 >= window_q) begin
            tick_q      <= `QEC_ZERO32;
            velocity_q  <= vel_acc_q + {31'h0, ev_div};
            vel_acc_q   <= `QEC_ZERO32;
            vel_valid_q <= 1'b1;
         end else begin
            tick_q    <= tick_q + 32'h1;
            vel_acc_q <= vel_acc_q + {31'h0, ev_div};
         end
      end
   end

   // read channel, one read at a time, data registered
   assign s_axi_arready = ~s_axi_rvalid;
   assign ar_fire       = s_axi_arvalid & s_axi_arready;

   always_ff @(posedge clock) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= qec_pkg::QEC_RESP_OKAY;
      end else if (ar_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= qec_pkg::QEC_RESP_OKAY;
         unique case ({2'b00, s_axi_araddr[7:2]})
            `QEC_CONFIG_OFF >> 2:    s_axi_rdata <= {27'h0, config_q};
            `QEC_CONTROL_OFF >> 2:   s_axi_rdata <= {31'h0, run_q};
            `QEC_LIMIT_OFF >> 2:     s_axi_rdata <= limit_q;
            `QEC_WINDOW_OFF >> 2:    s_axi_rdata <= window_q;
            `QEC_DIVIDER_OFF >> 2:   s_axi_rdata <= divider_q;
            `QEC_POSITION_OFF >> 2:  s_axi_rdata <= position_q;
            `QEC_DIRECTION_OFF >> 2: s_axi_rdata <= direction_q;
            `QEC_VELOCITY_OFF >> 2:  s_axi_rdata <= velocity_q;
            `QEC_STATUS_OFF >> 2:    s_axi_rdata <= {30'h0, vel_valid_q,
                                                     run_q};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= qec_pkg::QEC_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // stop freezes the position
   a_stop_freeze: assert property (@(posedge clock) disable iff (reset)
      (!run_q && !pos_write) |=> $stable(position_q))
      else $error("position moved while stopped");

   // index clear zeroes position next cycle
   a_index_clear: assert property (@(posedge clock) disable iff (reset)
      (run_q && !pos_write && ev.index && config_q[`QEC_CFG_INDEX])
      |=> position_q == `QEC_ZERO32)
      else $error("index did not clear position");

   // counting up onto the limit wraps to zero
   a_wrap_zero: assert property (@(posedge clock) disable iff (reset)
      (run_q && !pos_write && !ev.index && ev.step && ev.up &&
       position_q + 32'h1 == limit_q) |=> position_q == `QEC_ZERO32)
      else $error("counter did not wrap at limit");

   // direction is always plus or minus one
   a_dir_value: assert property (@(posedge clock) disable iff (reset)
      direction_q == `QEC_DIR_FWD || direction_q == `QEC_DIR_REV)
      else $error("direction value illegal");

   // software write lands
   a_pos_write: assert property (@(posedge clock) disable iff (reset)
      pos_write |=> position_q == $past(wr_word))
      else $error("position write lost");

   // zero window keeps velocity off
   a_vel_off: assert property (@(posedge clock) disable iff (reset)
      (window_q == `QEC_ZERO32) |=> !vel_valid_q)
      else $error("velocity active with zero window");

   // in phase-a-only mode a lone b edge gives no step
   a_single_phase: assert property (@(posedge clock) disable iff (reset)
      (!config_q[`QEC_CFG_BOTH] && !config_q[`QEC_CFG_STEP_DIR] &&
       $stable(config_q) &&
       $stable(sync2_q[config_q[`QEC_CFG_EXCHANGE]])) |-> !ev.step)
      else $error("step without phase a edge");

   // a forward step reports plus one
   a_dir_follow: assert property (@(posedge clock) disable iff (reset)
      (run_q && !pos_write && !(ev.index && config_q[`QEC_CFG_INDEX]) &&
       ev.step) |=> direction_q == ($past(ev.up) ? `QEC_DIR_FWD
                                                  : `QEC_DIR_REV))
      else $error("direction not updated by step");

   // a read answers one cycle after it is taken
   a_read_answer: assert property (@(posedge clock) disable iff (reset)
      ar_fire |=> s_axi_rvalid)
      else $error("read not answered");
endmodule : qec_counter

/* File: qec_defines.svh */
`ifndef QEC_DEFINES_SVH
`define QEC_DEFINES_SVH
// register byte offsets
`define QEC_CONFIG_OFF   8'h00
`define QEC_CONTROL_OFF  8'h04
`define QEC_LIMIT_OFF    8'h08
`define QEC_WINDOW_OFF   8'h0C
`define QEC_DIVIDER_OFF  8'h10
`define QEC_POSITION_OFF 8'h14
`define QEC_DIRECTION_OFF 8'h18
`define QEC_VELOCITY_OFF 8'h1C
`define QEC_STATUS_OFF   8'h20
// configuration field positions
`define QEC_CFG_EXCHANGE 1
`define QEC_CFG_STEP_DIR 2
`define QEC_CFG_BOTH     3
`define QEC_CFG_INDEX    4
// control field positions
`define QEC_CTL_RUN      0
// reset and direction values
`define QEC_ZERO32       32'h0000_0000
`define QEC_DIR_FWD      32'h0000_0001
`define QEC_DIR_REV      32'hFFFF_FFFF
`endif

/* File: qec_edge_decode.sv */
`timescale 1ns/10ps
`include "qec_defines.svh"
module qec_edge_decode (
   // clock and reset
   input  wire logic  clock,
   input  wire logic  reset,
   // synchronised pins
   input  wire logic  pha,
   input  wire logic  phb,
   input  wire logic  idx,
   // configuration
   input  wire logic  exchange,
   input  wire logic  step_dir_select,
   input  wire logic  count_both_phases,
   // decoded events
   qec_step_if.src    ev
);
   logic a_q;
   logic b_q;
   logic i_q;
   logic a;
   logic b;

   // swap before anything looks at the phases
   assign a = exchange ? phb : pha;
   assign b = exchange ? pha : phb;

   // previous levels for edge detection
   always_ff @(posedge clock) begin
      if (reset) begin
         a_q <= 1'b0;
         b_q <= 1'b0;
         i_q <= 1'b0;
      end else begin
         a_q <= a;
         b_q <= b;
         i_q <= idx;
      end
   end

   // event decode; a leading b counts up
   always_comb begin
      ev.step = 1'b0;
      ev.up   = 1'b0;
      if (step_dir_select) begin
         ev.step = a & ~a_q;
         ev.up   = b;
      end else if ((a ^ a_q) & ~(b ^ b_q)) begin
         ev.step = 1'b1;
         ev.up   = a ^ b;
      end else if ((b ^ b_q) & ~(a ^ a_q)) begin
         ev.step = count_both_phases;
         ev.up   = ~(a ^ b);
      end
   end

   // rising edge of index
   assign ev.index = idx & ~i_q;
endmodule : qec_edge_decode

/* File: qec_enc_model.sv */
`timescale 1ns/10ps
// encoder stand-in: one pin moves at a time, then rests
module qec_enc_model (
   // clock
   input  wire logic clock,
   // encoder pins
   output logic      enc_a,
   output logic      enc_b,
   output logic      enc_index
);
   // rest well above the two-cycle minimum, eight clocks a step
   localparam int HOLD = 7;

   // pins idle low
   initial begin
      enc_a = 1'b0;
      enc_b = 1'b0;
      enc_index = 1'b0;
   end

   // gray walk: a leads b by a quarter period when moving forward
   task automatic quad_step(input bit fwd);
      @(posedge clock);
      if ((enc_a == enc_b) == fwd)
         enc_a <= !enc_a;
      else
         enc_b <= !enc_b;
      repeat (HOLD) @(posedge clock);
   endtask : quad_step

   // step mode: step pin parks low first, so the rise is a real edge
   task automatic step_dir(input bit up);
      @(posedge clock);
      enc_a <= 1'b0;
      enc_b <= up;
      repeat (HOLD) @(posedge clock);
      enc_a <= 1'b1;
      repeat (HOLD) @(posedge clock);
      enc_a <= 1'b0;
      repeat (HOLD) @(posedge clock);
   endtask : step_dir

   // one pulse as the reference point passes
   task automatic index_pulse();
      @(posedge clock);
      enc_index <= 1'b1;
      repeat (HOLD) @(posedge clock);
      enc_index <= 1'b0;
      repeat (HOLD) @(posedge clock);
   endtask : index_pulse
endmodule : qec_enc_model

/* File: qec_pkg.sv */
package qec_pkg;
   typedef enum logic [1:0] {
      QEC_RESP_OKAY   = 2'b00,
      QEC_RESP_SLVERR = 2'b10
   } qec_resp_t;
   typedef enum logic [1:0] {
      QEC_WR_IDLE = 2'b00,
      QEC_WR_RESP = 2'b01
   } qec_wr_state_t;
endpackage : qec_pkg

/* File: qec_step_if.sv */
`timescale 1ns/10ps
interface qec_step_if;
   logic step;
   logic up;
   logic index;
   modport src (output step, output up, output index);
   modport dst (input step, input up, input index);
endinterface : qec_step_if

/* File: tb.sv */
`timescale 1ns/10ps
// self-checking bench for the encoder counter
module tb;
   logic        clock, reset, enc_a, enc_b, enc_index;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, exp_pos, exp_dir, lim, lfsr_q, r, v;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rs;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [4:0]  cfg;
   bit          run;
   int          error_cnt, n_compared, cyc;

   qec_counter i_dut (.clock(clock), .reset(reset), .enc_a(enc_a),
      .enc_b(enc_b), .enc_index(enc_index), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   qec_enc_model i_enc (.clock(clock), .enc_a(enc_a), .enc_b(enc_b),
      .enc_index(enc_index));

   // 50 MHz clock
   initial clock = 1'b0;
   always #10 clock = ~clock;

   // hang guard: far above the expected run of some 2300 cycles
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         error_cnt++;
         summarize();
      end
   end

   task automatic summarize();
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize

   task automatic chk32(input string n, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask : chk32

   task automatic chkr(input string n, input logic [1:0] e, g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask : chkr

   // window edges fall at an unknown phase, so one count either way
   task automatic chk_near(input string n, input logic [31:0] e, g);
      n_compared++;
      if (g !== e && g !== e + 32'h1 && g !== e - 32'h1) begin
         error_cnt++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask : chk_near

   // handshakes judged at the negedge, released after the next posedge
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] e);
      bit ta, tw, b;
      logic [1:0] got;
      b = 0;
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b) begin
         @(negedge clock);
         ta = awvalid && awready;
         tw = wvalid && wready;
         b = bvalid && bready;
         got = bresp;
         @(posedge clock);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (b) bready <= 1'b0;
      end
      chkr("bresp", e, got);
   endtask : wr

   task automatic rdw(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] rp);
      bit ta, got;
      got = 0;
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!got) begin
         @(negedge clock);
         ta = arvalid && arready;
         got = rvalid && rready;
         d = rdata;
         rp = rresp;
         @(posedge clock);
         if (ta) arvalid <= 1'b0;
         if (got) rready <= 1'b0;
      end
   endtask : rdw

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                         input string n);
      logic [31:0] d;
      logic [1:0]  p;
      rdw(a, d, p);
      chk32(n, e, d);
      chkr(n, 2'b00, p);
   endtask : rd_chk

   // expected next count: range is zero to limit minus one
   function automatic logic [31:0] nxt(input logic [31:0] p, input bit up);
      if (up)
         return (p + 32'h1 == lim) ? 32'h0 : p + 32'h1;
      return (p == 32'h0) ? lim - 32'h1 : p - 32'h1;
   endfunction : nxt

   function automatic logic [31:0] lfsr_nx(input logic [31:0] x);
      return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
   endfunction : lfsr_nx

   task automatic setcfg(input logic [4:0] c);
      cfg = c;
      wr(8'h00, {27'h0, c}, 2'b00);
   endtask : setcfg

   task automatic setpos(input logic [31:0] p);
      exp_pos = p;
      wr(8'h14, p, 2'b00);
   endtask : setpos

   // quadrature moves; phase-a-only mode counts only the decoded a pin
   task automatic mv(input bit fwd, input int n);
      logic pa, pb;
      bit up, hit;
      repeat (n) begin
         pa = enc_a;
         pb = enc_b;
         i_enc.quad_step(fwd);
         up = fwd ^ cfg[1];
         hit = cfg[3] ? 1'b1 : (cfg[1] ? enc_b != pb : enc_a != pa);
         if (hit && run) begin
            exp_pos = nxt(exp_pos, up);
            exp_dir = up ? 32'h1 : 32'hFFFFFFFF;
         end
      end
   endtask : mv

   task automatic sd(input bit up);
      i_enc.step_dir(up);
      exp_pos = nxt(exp_pos, up);
      exp_dir = up ? 32'h1 : 32'hFFFFFFFF;
   endtask : sd

   task automatic chk_pd();
      rd_chk(8'h14, exp_pos, "position");
      rd_chk(8'h18, exp_dir, "direction");
   endtask : chk_pd

   // main sequence
   initial begin
      reset = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata, wstrb} = 52'h0;
      {error_cnt, n_compared, run, cfg} = 0;
      {exp_pos, lim, exp_dir, lfsr_q} = {64'h0, 32'h1, 32'h0D3BD072};
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      rd_chk(8'h00, 32'h0, "config");
      rd_chk(8'h18, 32'h1, "direction");
      rd_chk(8'h1C, 32'h0, "velocity");
      rd_chk(8'h20, 32'h0, "status");
      rdw(8'h24, r, rs);
      chkr("unmapped", 2'b10, rs);
      chk32("unmapped data", 32'h0, r);
      wr(8'h18, 32'h5, 2'b10);
      mv(1, 4);
      rd_chk(8'h14, exp_pos, "stopped");
      wr(8'h04, 32'h1, 2'b00);
      run = 1;
      rd_chk(8'h20, 32'h1, "status");
      mv(1, 4);
      chk_pd();
      mv(0, 4);
      chk_pd();
      setcfg(5'h08);
      mv(1, 8);
      chk_pd();
      setcfg(5'h0A);
      mv(1, 6);
      chk_pd();
      setcfg(5'h04);
      repeat (3) sd(1);
      chk_pd();
      sd(0);
      chk_pd();
      lim = 32'h5;
      wr(8'h08, lim, 2'b00);
      rd_chk(8'h08, lim, "limit");
      setcfg(5'h08);
      setpos(32'h3);
      mv(1, 3);
      chk_pd();
      mv(0, 2);
      chk_pd();
      setcfg(5'h18);
      setpos(32'h2);
      i_enc.index_pulse();
      exp_pos = 32'h0;
      rd_chk(8'h14, exp_pos, "index clear");
      setcfg(5'h08);
      setpos(32'h2);
      i_enc.index_pulse();
      rd_chk(8'h14, exp_pos, "index off");
      lim = 32'h0;
      wr(8'h08, lim, 2'b00);
      repeat (8) begin
         lfsr_q = lfsr_nx(lfsr_q);
         setcfg({1'b0, lfsr_q[0], 1'b0, lfsr_q[1], 1'b0});
         lfsr_q = lfsr_nx(lfsr_q);
         setpos({1'b0, lfsr_q[31:1]});
         mv(lfsr_q[0], 2 + int'(lfsr_q[3:1]));
         chk_pd();
      end
      wr(8'h04, 32'h0, 2'b00);
      run = 0;
      mv(1, 4);
      rd_chk(8'h14, exp_pos, "stopped");
      wr(8'h04, 32'h1, 2'b00);
      run = 1;
      mv(1, 8);
      rd_chk(8'h1C, 32'h0, "velocity off");
      // both phases: 50 events per 400-tick window, halved by the divider
      setcfg(5'h08);
      wr(8'h0C, 32'd400, 2'b00);
      wr(8'h10, 32'h2, 2'b00);
      fork
         mv(1, 150);
         begin
            repeat (900) @(posedge clock);
            rdw(8'h1C, v, rs);
         end
      join
      chk_near("velocity", 32'd25, v);
      rd_chk(8'h20, 32'h3, "status");
      rd_chk(8'h14, exp_pos, "position");
      summarize();
   end
endmodule : tb
